// ===== hdl/hc_regs.sv
// host-control register bank: rom map base, posted-write failure capture,
// vendor word, host control set/clear flags, rom read decode.
// assumes an axi4-lite master on one 40 mhz clock and serial-side request
// strobes from same-clock link logic; strap and eeprom inputs are pins.
`timescale 1ns/10ps
`default_nettype none

module hc_regs #(
    parameter logic PERMIT_DEFAULT = 1'b0
) (
    input wire logic REF_CLK_IN,
    input wire logic RST_IN,
    input wire logic [7:0] AWADDR_IN,
    input wire logic AWVALID_IN,
    output logic AWREADY_OUT,
    input wire logic [31:0] WDATA_IN,
    input wire logic [3:0] WSTRB_IN,
    input wire logic WVALID_IN,
    output logic WREADY_OUT,
    output logic [1:0] BRESP_OUT,
    output logic BVALID_OUT,
    input wire logic BREADY_IN,
    input wire logic [7:0] ARADDR_IN,
    input wire logic ARVALID_IN,
    output logic ARREADY_OUT,
    output logic [31:0] RDATA_OUT,
    output logic [1:0] RRESP_OUT,
    output logic RVALID_OUT,
    input wire logic RREADY_IN,
    input wire logic EEPROM_PRESENT_IN,
    input wire logic EEPROM_PERMIT_IN,
    input wire logic ROM_REQ_IN,
    input wire logic ROM_BLOCK_IN,
    input wire logic [47:0] ROM_OFFSET_IN,
    input wire logic BUS_RESET_IN,
    input wire logic POST_FAIL_IN,
    input wire logic [47:0] POST_OFFSET_IN,
    input wire logic [15:0] POST_NODE_IN,
    output logic ROM_HIT_OUT,
    output logic [31:0] ROM_ADDR_OUT,
    output logic ROM_TYPE_ERR_OUT,
    output logic ROM_SERVICE_OUT,
    output logic ROM_UPDATE_OUT,
    output logic TARDY_OK_OUT,
    output logic SWAP_OUT,
    output logic LINK_POWER_OUT,
    output logic POSTING_OUT,
    output logic LINK_ACTIVE_OUT
);
    // ----------------------------------------------------------------
    // state
    // ----------------------------------------------------------------
    typedef struct packed {
        logic [7:0] awaddr; // latched write address
        logic aw_have; // write address taken
        logic [31:0] wdata; // latched write data
        logic [3:0] wstrb; // latched strobes
        logic w_have; // write data taken
        logic bvalid; // write response pending
        logic [1:0] bresp; // write response code
        logic rvalid; // read data pending
        logic [31:0] rdata; // read data word
        logic [1:0] rresp; // read response code
        logic [31:0] base; // rom map base, low bits zero
        logic [31:0] ctrl; // control flags
        logic [31:0] fail_low; // failed posted write, low capture
        logic [31:0] fail_high; // failed posted write, high capture
        logic strap_done; // permit flag already loaded
        logic [1:0] ee_pres_s; // eeprom present synchroniser
        logic [1:0] ee_perm_s; // eeprom permit synchroniser
        logic rom_hit; // quadlet rom read mapped
        logic [31:0] rom_addr; // host address for it
        logic type_err; // block read refused
        logic service; // block read serviced
        logic update; // image refresh strobe
        logic tardy_ok; // tardy ack allowed
        logic aw_rdy; // write address ready, registered
        logic w_rdy; // write data ready, registered
        logic ar_rdy; // read address ready, registered
        logic swap_on; // payload byte swap active
    } state_t;

    state_t cur_ff; // registered state
    state_t nxt_cur; // next state

    logic [31:0] rd_word; // read mux output
    logic rd_hit; // read address decodes
    logic wr_hit; // write address decodes
    logic in_rom; // offset inside rom window
    logic link_on; // shorthand for link flag
    logic [31:0] wmask; // byte-lane mask from strobes
    logic [31:0] link_bit; // link flag position, kept out of set/clear writes

    // ----------------------------------------------------------------
    // read decode
    // ----------------------------------------------------------------
    // reads of either control address give the same flags
    always_comb begin
        rd_hit = 1'b1;
        case (ARADDR_IN)
            hc_regs_pkg::OFF_ROM_MAP_BASE: rd_word = cur_ff.base & hc_regs_pkg::BASE_MASK;
            hc_regs_pkg::OFF_FAIL_LOW: rd_word = cur_ff.fail_low;
            hc_regs_pkg::OFF_FAIL_HIGH: rd_word = cur_ff.fail_high;
            hc_regs_pkg::OFF_VENDOR: rd_word = hc_regs_pkg::VENDOR_WORD;
            hc_regs_pkg::OFF_CTRL_SET,
            hc_regs_pkg::OFF_CTRL_CLR: rd_word = cur_ff.ctrl & hc_regs_pkg::CLR_MASK;
            hc_regs_pkg::OFF_LINK_CTRL: rd_word = {31'h0, cur_ff.ctrl[hc_regs_pkg::BIT_LINK]};
            default: begin
                rd_word = 32'h00000000;
                rd_hit = 1'b0;
            end
        endcase
    end

    // ----------------------------------------------------------------
    // next-state logic
    // ----------------------------------------------------------------
    always_comb begin
        nxt_cur = cur_ff;
        link_on = cur_ff.ctrl[hc_regs_pkg::BIT_LINK];
        wr_hit = 1'b0;
        // the link flag only moves through its own address
        link_bit = 32'h00000001 << hc_regs_pkg::BIT_LINK;
        for (int i = 0; i < 4; i++) begin
            wmask[i*8 +: 8] = {8{cur_ff.wstrb[i]}};
        end
        // eeprom pins pass two flops before use
        nxt_cur.ee_pres_s = {cur_ff.ee_pres_s[0], EEPROM_PRESENT_IN};
        nxt_cur.ee_perm_s = {cur_ff.ee_perm_s[0], EEPROM_PERMIT_IN};
        // load permit once after reset, from eeprom if fitted
        if (!cur_ff.strap_done) begin
            nxt_cur.strap_done = 1'b1;
            nxt_cur.ctrl[hc_regs_pkg::BIT_PHY_PERMIT] = cur_ff.ee_pres_s[1] ?
                cur_ff.ee_perm_s[1] : PERMIT_DEFAULT;
        end
        // address and data channels taken independently
        if (AWVALID_IN && !cur_ff.aw_have && !cur_ff.bvalid) begin
            nxt_cur.aw_have = 1'b1;
            nxt_cur.awaddr = AWADDR_IN;
        end
        if (WVALID_IN && !cur_ff.w_have && !cur_ff.bvalid) begin
            nxt_cur.w_have = 1'b1;
            nxt_cur.wdata = WDATA_IN;
            nxt_cur.wstrb = WSTRB_IN;
        end
        if (cur_ff.aw_have && cur_ff.w_have) begin
            nxt_cur.aw_have = 1'b0;
            nxt_cur.w_have = 1'b0;
            nxt_cur.bvalid = 1'b1;
            wr_hit = 1'b1;
            case (cur_ff.awaddr)
                hc_regs_pkg::OFF_ROM_MAP_BASE: nxt_cur.base = ((cur_ff.base & ~wmask) |
                    (cur_ff.wdata & wmask)) & hc_regs_pkg::BASE_MASK;
                hc_regs_pkg::OFF_CTRL_SET: nxt_cur.ctrl = cur_ff.ctrl |
                    (cur_ff.wdata & wmask & hc_regs_pkg::SET_MASK);
                hc_regs_pkg::OFF_CTRL_CLR: nxt_cur.ctrl = cur_ff.ctrl &
                    ~(cur_ff.wdata & wmask & hc_regs_pkg::CLR_MASK & ~link_bit);
                hc_regs_pkg::OFF_LINK_CTRL: begin
                    if (cur_ff.wstrb[0]) begin
                        nxt_cur.ctrl[hc_regs_pkg::BIT_LINK] = cur_ff.wdata[0];
                    end
                end
                hc_regs_pkg::OFF_FAIL_LOW,
                hc_regs_pkg::OFF_FAIL_HIGH,
                hc_regs_pkg::OFF_VENDOR: wr_hit = 1'b1; // read-only, write dropped
                default: wr_hit = 1'b0;
            endcase
            nxt_cur.bresp = wr_hit ? hc_regs_pkg::RESP_OK : hc_regs_pkg::RESP_SLVERR;
        end
        if (cur_ff.bvalid && BREADY_IN) begin
            nxt_cur.bvalid = 1'b0;
        end
        // read channel: one outstanding, answer one cycle after address
        if (ARVALID_IN && !cur_ff.rvalid) begin
            nxt_cur.rvalid = 1'b1;
            nxt_cur.rdata = rd_word;
            nxt_cur.rresp = rd_hit ? hc_regs_pkg::RESP_OK : hc_regs_pkg::RESP_SLVERR;
        end else if (cur_ff.rvalid && RREADY_IN) begin
            nxt_cur.rvalid = 1'b0;
        end
        // serial side: no rom hit, block reply, refresh or failure capture while link is off; rom_addr and tardy_ok still follow
        in_rom = (ROM_OFFSET_IN >= hc_regs_pkg::ROM_LO) && (ROM_OFFSET_IN <= hc_regs_pkg::ROM_HI);
        nxt_cur.rom_hit = ROM_REQ_IN && link_on && in_rom && !ROM_BLOCK_IN;
        nxt_cur.rom_addr = cur_ff.base + {22'h0, ROM_OFFSET_IN[hc_regs_pkg::ROM_BITS-1:0]};
        nxt_cur.type_err = ROM_REQ_IN && link_on && in_rom && ROM_BLOCK_IN &&
            !cur_ff.ctrl[hc_regs_pkg::BIT_IMAGE_OK];
        nxt_cur.service = ROM_REQ_IN && link_on && in_rom && ROM_BLOCK_IN &&
            cur_ff.ctrl[hc_regs_pkg::BIT_IMAGE_OK];
        nxt_cur.update = BUS_RESET_IN && link_on &&
            cur_ff.ctrl[hc_regs_pkg::BIT_IMAGE_OK];
        nxt_cur.tardy_ok = cur_ff.ctrl[hc_regs_pkg::BIT_DEFER_ACK];
        // capture a failed posted write only when posting is enabled
        if (POST_FAIL_IN && link_on && cur_ff.ctrl[hc_regs_pkg::BIT_POSTING]) begin
            nxt_cur.fail_low = POST_OFFSET_IN[31:0];
            nxt_cur.fail_high = {POST_NODE_IN, POST_OFFSET_IN[47:32]};
        end
        // handshake readies and the swap select are registered so that
        // every port comes straight from a flop; they follow the next state
        nxt_cur.aw_rdy = !nxt_cur.aw_have && !nxt_cur.bvalid;
        nxt_cur.w_rdy = !nxt_cur.w_have && !nxt_cur.bvalid;
        nxt_cur.ar_rdy = !nxt_cur.rvalid;
        nxt_cur.swap_on = !nxt_cur.ctrl[hc_regs_pkg::BIT_SWAP_OFF];
        if (RST_IN) begin
            nxt_cur = '0;
            // synchronisers keep shifting through reset, so the one-shot
            // permit load right after release sees settled pin values
            nxt_cur.ee_pres_s = {cur_ff.ee_pres_s[0], EEPROM_PRESENT_IN};
            nxt_cur.ee_perm_s = {cur_ff.ee_perm_s[0], EEPROM_PERMIT_IN};
            nxt_cur.base = hc_regs_pkg::BASE_RESET;
            nxt_cur.ctrl = hc_regs_pkg::CTRL_RESET;
            // idle bus: all three channels ready, swapping on
            nxt_cur.aw_rdy = 1'b1;
            nxt_cur.w_rdy = 1'b1;
            nxt_cur.ar_rdy = 1'b1;
            nxt_cur.swap_on = 1'b1;
        end
    end

    // ----------------------------------------------------------------
    // registers
    // ----------------------------------------------------------------
    always_ff @(posedge REF_CLK_IN) begin
        cur_ff <= nxt_cur;
    end

    // ----------------------------------------------------------------
    // outputs, all straight from flops
    // ----------------------------------------------------------------
    assign AWREADY_OUT = cur_ff.aw_rdy;
    assign WREADY_OUT = cur_ff.w_rdy;
    assign BVALID_OUT = cur_ff.bvalid;
    assign BRESP_OUT = cur_ff.bresp;
    assign ARREADY_OUT = cur_ff.ar_rdy;
    assign RVALID_OUT = cur_ff.rvalid;
    assign RDATA_OUT = cur_ff.rdata;
    assign RRESP_OUT = cur_ff.rresp;
    assign ROM_HIT_OUT = cur_ff.rom_hit;
    assign ROM_ADDR_OUT = cur_ff.rom_addr;
    assign ROM_TYPE_ERR_OUT = cur_ff.type_err;
    assign ROM_SERVICE_OUT = cur_ff.service;
    assign ROM_UPDATE_OUT = cur_ff.update;
    assign TARDY_OK_OUT = cur_ff.tardy_ok;
    assign SWAP_OUT = cur_ff.swap_on;
    assign LINK_POWER_OUT = cur_ff.ctrl[hc_regs_pkg::BIT_LPS];
    assign POSTING_OUT = cur_ff.ctrl[hc_regs_pkg::BIT_POSTING];
    assign LINK_ACTIVE_OUT = link_on;

    // ----------------------------------------------------------------
    // assertions
    // ----------------------------------------------------------------
    sequence s_block_rom;
        ROM_REQ_IN && ROM_BLOCK_IN && link_on && in_rom;
    endsequence

    a_base_low_zero: assert property (@(posedge REF_CLK_IN) disable iff (RST_IN)
        cur_ff.base[9:0] == 10'h000) else $error("base low bits not zero");
    a_rom_addr_sum: assert property (@(posedge REF_CLK_IN) disable iff (RST_IN)
        ROM_REQ_IN && !ROM_BLOCK_IN && link_on && in_rom |=> ROM_HIT_OUT &&
        ROM_ADDR_OUT == $past(cur_ff.base) + {22'h0, $past(ROM_OFFSET_IN[9:0])})
        else $error("rom address wrong");
    a_type_error: assert property (@(posedge REF_CLK_IN) disable iff (RST_IN)
        s_block_rom and !cur_ff.ctrl[31] |=> ROM_TYPE_ERR_OUT && !ROM_SERVICE_OUT)
        else $error("block read not refused");
    a_block_serve: assert property (@(posedge REF_CLK_IN) disable iff (RST_IN)
        s_block_rom and cur_ff.ctrl[31] |=> ROM_SERVICE_OUT && !ROM_TYPE_ERR_OUT)
        else $error("block read not serviced");
    a_capture_pair: assert property (@(posedge REF_CLK_IN) disable iff (RST_IN)
        POST_FAIL_IN && link_on && POSTING_OUT |=> cur_ff.fail_low == $past(POST_OFFSET_IN[31:0])
        && cur_ff.fail_high == {$past(POST_NODE_IN), $past(POST_OFFSET_IN[47:32])})
        else $error("posted failure not captured");
    a_link_quiet: assert property (@(posedge REF_CLK_IN) disable iff (RST_IN)
        !link_on |=> !ROM_HIT_OUT && !ROM_SERVICE_OUT && !ROM_TYPE_ERR_OUT)
        else $error("activity with link off");
    a_reserved_zero: assert property (@(posedge REF_CLK_IN) disable iff (RST_IN)
        cur_ff.ctrl[28:24] == 5'h00 && cur_ff.ctrl[21:20] == 2'h0)
        else $error("reserved bits set");
    a_vendor_const: assert property (@(posedge REF_CLK_IN) disable iff (RST_IN)
        ARVALID_IN && ARREADY_OUT && ARADDR_IN == hc_regs_pkg::OFF_VENDOR |=>
        RVALID_OUT && RDATA_OUT == hc_regs_pkg::VENDOR_WORD) else $error("vendor word wrong");
    a_set_flags: assert property (@(posedge REF_CLK_IN) disable iff (RST_IN)
        cur_ff.aw_have && cur_ff.w_have && cur_ff.awaddr == hc_regs_pkg::OFF_CTRL_SET &&
        cur_ff.wstrb[3] && cur_ff.wdata[30] |=> cur_ff.ctrl[30]) else $error("set failed");
    a_power_follow: assert property (@(posedge REF_CLK_IN) disable iff (RST_IN)
        LINK_POWER_OUT == cur_ff.ctrl[19] && SWAP_OUT == !cur_ff.ctrl[30])
        else $error("flag outputs wrong");
    // set and clear writes must never move the link flag
    a_link_kept: assert property (@(posedge REF_CLK_IN) disable iff (RST_IN)
        cur_ff.aw_have && cur_ff.w_have && cur_ff.awaddr != hc_regs_pkg::OFF_LINK_CTRL |=>
        $stable(LINK_ACTIVE_OUT)) else $error("link flag moved by other write");
    // a clear write with a one drops that flag, bar the link flag
    a_clear_flags: assert property (@(posedge REF_CLK_IN) disable iff (RST_IN)
        cur_ff.aw_have && cur_ff.w_have && cur_ff.awaddr == hc_regs_pkg::OFF_CTRL_CLR &&
        cur_ff.wstrb[3] && cur_ff.wdata[29] |=> !cur_ff.ctrl[29]) else $error("clear failed");
    // tardy permission trails its flag by one cycle
    a_tardy_follow: assert property (@(posedge REF_CLK_IN) disable iff (RST_IN)
        TARDY_OK_OUT == $past(cur_ff.ctrl[hc_regs_pkg::BIT_DEFER_ACK]))
        else $error("tardy flag wrong");
    // with posting off a failure leaves both captures alone
    a_posting_gate: assert property (@(posedge REF_CLK_IN) disable iff (RST_IN)
        POST_FAIL_IN && !POSTING_OUT |=> $stable(cur_ff.fail_low) && $stable(cur_ff.fail_high))
        else $error("capture with posting off");
    // no image refresh while the image is marked invalid
    a_update_gate: assert property (@(posedge REF_CLK_IN) disable iff (RST_IN)
        BUS_RESET_IN && !cur_ff.ctrl[hc_regs_pkg::BIT_IMAGE_OK] |=> !ROM_UPDATE_OUT)
        else $error("refresh with image invalid");
endmodule // hc_regs

`default_nettype wire

// ===== pkg/hc_regs_pkg.sv
// package for the host-control register bank: offsets, field positions,
// reset values and serial-side constants.
// assumes a 32-bit axi4-lite slave with byte addresses equal to offsets.
package hc_regs_pkg;
    // ----------------------------------------------------------------
    // register offsets
    // ----------------------------------------------------------------
    localparam logic [7:0] OFF_ROM_MAP_BASE = 8'h34;
    localparam logic [7:0] OFF_FAIL_LOW = 8'h38;
    localparam logic [7:0] OFF_FAIL_HIGH = 8'h3c;
    localparam logic [7:0] OFF_VENDOR = 8'h40;
    localparam logic [7:0] OFF_CTRL_SET = 8'h50;
    localparam logic [7:0] OFF_CTRL_CLR = 8'h54;
    localparam logic [7:0] OFF_LINK_CTRL = 8'h58;
    // ----------------------------------------------------------------
    // field layout
    // ----------------------------------------------------------------
    localparam int BASE_LSB = 10;
    localparam logic [31:0] BASE_MASK = 32'hfffffc00;
    localparam int BIT_IMAGE_OK = 31;
    localparam int BIT_SWAP_OFF = 30;
    localparam int BIT_DEFER_ACK = 29;
    localparam int BIT_PHY_PERMIT = 23;
    localparam int BIT_ENH_ON = 22;
    localparam int BIT_LPS = 19;
    localparam int BIT_POSTING = 18;
    localparam int BIT_LINK = 17;
    // bits the set address may raise; permit bit is clear-only and the
    // link flag lives at its own address, so neither is in this mask
    localparam logic [31:0] SET_MASK = 32'he04c0000;
    // bits the clear address may drop, bar the link flag at bit 17; also the control read mask
    localparam logic [31:0] CLR_MASK = 32'he0ce0000;
    localparam logic [31:0] CTRL_RESET = 32'h00000000;
    localparam logic [31:0] BASE_RESET = 32'h00000000;
    // arbitrary neutral identity value
    localparam logic [31:0] VENDOR_WORD = 32'h00000000;
    // ----------------------------------------------------------------
    // serial-side constants
    // ----------------------------------------------------------------
    localparam logic [47:0] ROM_LO = 48'hfffff0000400;
    localparam logic [47:0] ROM_HI = 48'hfffff00007ff;
    localparam int ROM_BITS = 10;
    localparam logic [1:0] RESP_OK = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;
endpackage

// ===== verification/hc_far_end.sv
// far-end model: remote serial nodes that issue rom reads, bus resets
// and posted-write failures toward the register bank.
// assumes the bench calls one task at a time on the shared clock.
`timescale 1ns/10ps
`default_nettype none
module hc_far_end (
    input wire logic clk_in,
    output var logic rom_req_out,
    output var logic rom_block_out,
    output var logic [47:0] rom_offset_out,
    output var logic bus_reset_out,
    output var logic post_fail_out,
    output var logic [47:0] post_offset_out,
    output var logic [15:0] post_node_out
);
    // quiet lines at time zero; qualifiers carry junk between requests
    initial begin
        rom_req_out = 1'b0;
        rom_block_out = 1'b1;
        rom_offset_out = 48'hffffffffffff;
        bus_reset_out = 1'b0;
        post_fail_out = 1'b0;
        post_offset_out = 48'h000000000000;
        post_node_out = 16'hffff;
    end
    // one-cycle read strobe; released qualifiers show the inverse value
    task automatic send_rom(input logic [47:0] off, input logic blk);
        @(posedge clk_in);
        rom_req_out <= 1'b1;
        rom_block_out <= blk;
        rom_offset_out <= off;
        @(posedge clk_in);
        rom_req_out <= 1'b0;
        rom_block_out <= ~blk;
        rom_offset_out <= ~off;
    endtask
    // bus reset seen by the link as a single-cycle event
    task automatic send_reset();
        @(posedge clk_in);
        bus_reset_out <= 1'b1;
        @(posedge clk_in);
        bus_reset_out <= 1'b0;
    endtask
    // failed posted write with its destination and requester
    task automatic send_fail(input logic [47:0] off, input logic [15:0] node);
        @(posedge clk_in);
        post_fail_out <= 1'b1;
        post_offset_out <= off;
        post_node_out <= node;
        @(posedge clk_in);
        post_fail_out <= 1'b0;
        post_offset_out <= ~off;
        post_node_out <= ~node;
    endtask
endmodule // hc_far_end
`default_nettype wire

// ===== verification/hc_regs_bench.sv
// bench for the host-control register bank: axi4-lite master tasks,
// an integer register model and the serial far-end model beside it.
// assumes one 40 mhz clock and eeprom pins steady from time zero.
`timescale 1ns/10ps
`default_nettype none
module hc_regs_bench;
    // ------------------------------------------------------------
    // signals and model state
    // ------------------------------------------------------------
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic [7:0] awaddr = 8'h00, araddr = 8'h00;
    logic [31:0] wdata = 32'h00000000;
    logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
    logic awready, wready, bvalid, arready, rvalid, rom_hit, terr, svc, upd;
    logic tardy, swap, lpow, posting, link_act, rom_req, rom_blk, bus_rst, pf;
    logic [1:0] bresp, rresp;
    logic [31:0] rdata, rom_addr;
    logic [47:0] rom_off, poff;
    logic [15:0] pnode;
    // the link bit lives at its own address, so m_ctrl never holds bit 17
    int m_ctrl, m_base, m_lo, m_hi, m_link, errors, cmp_count, seed;
    logic [7:0] ra[6] = '{8'h34, 8'h40, 8'h50, 8'h54, 8'h58, 8'h00};
    logic [47:0] q[$];
    always #12.5 clk = ~clk;
    hc_regs hc_regs_i (.REF_CLK_IN(clk), .RST_IN(rst), .AWADDR_IN(awaddr),
        .AWVALID_IN(awvalid), .AWREADY_OUT(awready), .WDATA_IN(wdata), .WSTRB_IN(4'hf),
        .WVALID_IN(wvalid), .WREADY_OUT(wready), .BRESP_OUT(bresp), .BVALID_OUT(bvalid),
        .BREADY_IN(bready), .ARADDR_IN(araddr), .ARVALID_IN(arvalid), .ARREADY_OUT(arready),
        .RDATA_OUT(rdata), .RRESP_OUT(rresp), .RVALID_OUT(rvalid), .RREADY_IN(rready),
        .EEPROM_PRESENT_IN(1'b1), .EEPROM_PERMIT_IN(1'b1), .ROM_REQ_IN(rom_req),
        .ROM_BLOCK_IN(rom_blk), .ROM_OFFSET_IN(rom_off), .BUS_RESET_IN(bus_rst),
        .POST_FAIL_IN(pf), .POST_OFFSET_IN(poff), .POST_NODE_IN(pnode), .ROM_HIT_OUT(rom_hit),
        .ROM_ADDR_OUT(rom_addr), .ROM_TYPE_ERR_OUT(terr), .ROM_SERVICE_OUT(svc),
        .ROM_UPDATE_OUT(upd), .TARDY_OK_OUT(tardy), .SWAP_OUT(swap), .LINK_POWER_OUT(lpow),
        .POSTING_OUT(posting), .LINK_ACTIVE_OUT(link_act));
    hc_far_end hc_far_end_i (.clk_in(clk), .rom_req_out(rom_req), .rom_block_out(rom_blk),
        .rom_offset_out(rom_off), .bus_reset_out(bus_rst), .post_fail_out(pf),
        .post_offset_out(poff), .post_node_out(pnode));
    // ------------------------------------------------------------
    // compares, verdict and the register model
    // ------------------------------------------------------------
    task automatic chk_word(input string nm, input logic [31:0] e, input logic [31:0] g);
        cmp_count++;
        if (g !== e) begin
            errors++;
            $display("MISMATCH %s expected %h seen %h", nm, e, g);
        end
    endtask
    task automatic chk_flag(input string nm, input logic e, input logic g);
        chk_word(nm, {31'h0, e}, {31'h0, g});
    endtask
    task automatic results();
        $display("comparisons %0d mismatches %0d", cmp_count, errors);
        if (errors == 0 && cmp_count > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask
    // expected {resp, data} of a read at one byte address
    function automatic logic [33:0] mdl_rd(input logic [7:0] a);
        case (a)
            8'h34: return {2'h0, 32'(m_base)};
            8'h38: return {2'h0, 32'(m_lo)};
            8'h3c: return {2'h0, 32'(m_hi)};
            8'h40: return {2'h0, hc_regs_pkg::VENDOR_WORD};
            8'h50, 8'h54: return {2'h0, 32'(m_ctrl | (m_link << 17))};
            8'h58: return {2'h0, 32'(m_link)};
            default: return {hc_regs_pkg::RESP_SLVERR, 32'h0};
        endcase
    endfunction
    // write: both channels offered at once, each dropped when taken
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic [1:0] r;
        logic got;
        int n;
        got = 1'b0;
        @(posedge clk);
        awaddr <= a;
        wdata <= d;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        for (n = 0; n < 40 && !got; n++) begin
            @(posedge clk);
            if (awvalid && awready) awvalid <= 1'b0;
            if (wvalid && wready) wvalid <= 1'b0;
            if (bvalid) begin
                r = bresp;
                bready <= 1'b0;
                got = 1'b1;
            end
        end
        if (!got) begin
            errors++;
            results();
        end
        chk_word("bresp", 32'(mdl_rd(a)[33:32]), 32'(r));
        case (a)
            8'h34: m_base = d & hc_regs_pkg::BASE_MASK;
            8'h50: m_ctrl = m_ctrl | (d & hc_regs_pkg::SET_MASK);
            8'h54: m_ctrl = m_ctrl & ~(d & hc_regs_pkg::CLR_MASK);
            8'h58: m_link = d[0];
            default: ;
        endcase
        repeat (2) @(posedge clk);
        #1;
        chk_flag("swap", !m_ctrl[30], swap);
        chk_flag("tardy", m_ctrl[29], tardy);
        chk_flag("lps", m_ctrl[19], lpow);
        chk_flag("posting", m_ctrl[18], posting);
        chk_flag("link", m_link == 1, link_act);
    endtask
    task automatic rd(input logic [7:0] a);
        logic [33:0] g;
        logic got;
        int n;
        got = 1'b0;
        @(posedge clk);
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        for (n = 0; n < 40 && !got; n++) begin
            @(posedge clk);
            if (arvalid && arready) arvalid <= 1'b0;
            if (rvalid) begin
                g = {rresp, rdata};
                rready <= 1'b0;
                got = 1'b1;
            end
        end
        if (!got) begin
            errors++;
            results();
        end
        chk_word("rdata", mdl_rd(a)[31:0], g[31:0]);
        chk_word("rresp", 32'(mdl_rd(a)[33:32]), 32'(g[33:32]));
    endtask
    // serial rom read; outputs are one-cycle pulses, looked at in that cycle
    task automatic rom(input logic [47:0] off, input logic blk);
        logic win;
        win = off >= hc_regs_pkg::ROM_LO && off <= hc_regs_pkg::ROM_HI && m_link == 1;
        hc_far_end_i.send_rom(off, blk);
        #1;
        chk_flag("rom_hit", win && !blk, rom_hit);
        if (win && !blk) chk_word("rom_addr", 32'(m_base) + 32'(off[9:0]), rom_addr);
        chk_flag("type_err", win && blk && !m_ctrl[31], terr);
        chk_flag("service", win && blk && m_ctrl[31], svc);
    endtask
    task automatic brst();
        hc_far_end_i.send_reset();
        #1;
        chk_flag("rom_update", m_ctrl[31] && m_link == 1, upd);
    endtask
    task automatic post(input logic [47:0] off, input logic [15:0] node);
        hc_far_end_i.send_fail(off, node);
        if (m_link == 1 && m_ctrl[18]) begin
            m_lo = off[31:0];
            m_hi = {node, off[47:32]};
        end
        rd(8'h38);
        rd(8'h3c);
    endtask
    // ------------------------------------------------------------
    // main sequence
    // ------------------------------------------------------------
    initial begin
        seed = $urandom(24);
        errors = 0;
        cmp_count = 0;
        m_link = 0;
        m_base = 0;
        m_ctrl = 32'h00800000;
        repeat (3) @(posedge clk);
        rst <= 1'b0;
        repeat (2) @(posedge clk);
        foreach (ra[i]) rd(ra[i]);
        $display("test reset values done");
        wr(8'h34, 32'hffffffff);
        rd(8'h34);
        wr(8'h34, $urandom());
        rd(8'h34);
        $display("test rom base done");
        wr(8'h50, 32'hffffffff);
        wr(8'h54, 32'h60000000);
        wr(8'h54, 32'h00000000);
        wr(8'h40, 32'hffffffff);
        foreach (ra[i]) rd(ra[i]);
        wr(8'h50, 32'h20000000);
        wr(8'h54, 32'h00800000);
        wr(8'h50, 32'h00800000);
        rd(8'h54);
        $display("test set clear done");
        wr(8'h58, 32'h00000001);
        wr(8'h54, 32'h00020000);
        rd(8'h50);
        q = {hc_regs_pkg::ROM_LO, hc_regs_pkg::ROM_HI, hc_regs_pkg::ROM_LO - 48'h1};
        q.push_back(hc_regs_pkg::ROM_HI + 48'h1);
        q.push_back(hc_regs_pkg::ROM_LO + 48'($urandom() % 1024));
        foreach (q[i]) begin
            rom(q[i], 1'b0);
            rom(q[i], 1'b1);
        end
        brst();
        wr(8'h54, 32'h80000000);
        rom(hc_regs_pkg::ROM_LO + 48'h8, 1'b1);
        brst();
        wr(8'h58, 32'h00000000);
        rom(hc_regs_pkg::ROM_LO + 48'h4, 1'b0);
        $display("test rom reads done");
        wr(8'h58, 32'h00000001);
        post(48'({$urandom(), $urandom()}), 16'($urandom()));
        wr(8'h58, 32'h00000000);
        wr(8'h54, 32'h00040000);
        wr(8'h58, 32'h00000001);
        post(48'({$urandom(), $urandom()}), 16'($urandom()));
        $display("test posted failure done");
        results();
    end
endmodule // hc_regs_bench
`default_nettype wire
